// *** gcc_chk.sv ***
// Checker of gcc_top: bus answer timing, arming commands and bank changes.
// Assumes AW and W are offered together and every BVALID is taken at once.
`timescale 1ns/1ps
`default_nettype none
module gcc_chk
  import gcc_pkg::*;
(
  input wire logic              MCLK_I,
  input wire logic              RST_B_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic              S_AXI_AWVALID_I,
  input wire logic              S_AXI_AWREADY_O,
  input wire logic [31:0]       S_AXI_WDATA_I,
  input wire logic              S_AXI_WVALID_I,
  input wire logic              S_AXI_WREADY_O,
  input wire logic              S_AXI_BVALID_O,
  input wire logic              S_AXI_ARVALID_I,
  input wire logic              S_AXI_ARREADY_O,
  input wire logic              S_AXI_RVALID_O,
  input wire logic [NCNT-1:0]   ARMED_O,
  input wire logic [NCNT-1:0]   ACTIVE_BANK_O
);
  default clocking dc @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence s_wr;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  // Command write to counter 0 whose masked bits equal v
  sequence s_cmd0(logic [15:0] m, logic [15:0] v);
    s_wr ##0 (S_AXI_AWADDR_I[11:2] == IDX_CMD[0]) && ((S_AXI_WDATA_I[15:0] & m) == v);
  endsequence

  chk_write_answer: assert property (s_wr |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O)
    else $error("write response not two cycles after the taken edge");
  chk_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read data not one cycle after the taken edge");
  chk_read_refuse: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address accepted while read data pending");
  chk_arm_own: assert property (s_cmd0(16'h0001, 16'h0001) |-> ##2 ARMED_O[0])
    else $error("run strobe did not arm counter 0");
  chk_arm_partner: assert property (s_cmd0(16'h2000, 16'h2000) |-> ##2 ARMED_O[1])
    else $error("partner run did not arm counter 1");
  chk_stop_own: assert property (s_cmd0(16'h0011, 16'h0010) |-> ##2 !ARMED_O[0])
    else $error("stop strobe did not disarm counter 0");
  chk_stop_partner: assert property (s_cmd0(16'ha000, 16'h8000) |-> ##2 !ARMED_O[1])
    else $error("partner stop did not disarm counter 1");
  chk_bank_armed: assert property ($changed(ACTIVE_BANK_O[2]) |-> $past(ARMED_O[2]))
    else $error("bank of counter 2 changed while disarmed");
endmodule : gcc_chk

bind gcc_top gcc_chk chk_u (
  .MCLK_I, .RST_B_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
  .S_AXI_RVALID_O, .ARMED_O, .ACTIVE_BANK_O
);
`default_nettype wire

// *** gcc_pkg.sv ***
// Constants and types of the counter command and bank control block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
package gcc_pkg;

  localparam int NCNT   = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam int STEP_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_STEP [4] = '{10'h088, 10'h00a, 10'h188, 10'h18a};
  localparam logic [9:0] IDX_CMD  [4] = '{10'h00c, 10'h00e, 10'h10c, 10'h10e};
  localparam logic [9:0] IDX_UPPER_STATUS = 10'h136;
  localparam logic [9:0] IDX_LOAD_A_BASE  = 10'h300;
  localparam logic [9:0] IDX_LOAD_B_BASE  = 10'h304;
  localparam logic [9:0] IDX_SAVE_BASE    = 10'h308;
  localparam logic [9:0] IDX_STATUS       = 10'h30c;
  localparam logic [9:0] IDX_CTRL         = 10'h30d;

  // Field positions
  localparam int UST_BANK_LSB    = 0;
  localparam int UST_GATE_LSB    = 2;
  localparam int ST_ARMED_LSB    = 0;
  localparam int ST_DONE_LSB     = 4;
  localparam int ST_GATE_LSB     = 8;
  localparam int ST_BANK_LSB     = 12;
  localparam int CTRL_POL_LSB    = 0;
  localparam int CTRL_PRESET_LSB = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       BANK_X      = 1'b0;
  localparam logic [STEP_W-1:0] STEP_RESET = 8'h00;

  typedef enum logic [1:0] {DIR_DOWN, DIR_UP, DIR_PIN, DIR_GATE} gcc_dir_e;

  typedef struct packed {
    logic     partner_disarm;
    logic     partner_snapshot_control;
    logic     partner_arm;
    logic     swap_enable;
    logic     swap_trigger_select;
    logic     swap_request;
    logic     half_word_select;
    logic     gate_resync_enable;
    logic     inactive_bank_redirect;
    gcc_dir_e count_direction_field;
    logic     stop_strobe;
    logic     unused_bit3;
    logic     preset_strobe;
    logic     snapshot_control;
    logic     run_strobe;
  } gcc_cmd_s;

  typedef struct packed {
    logic     snapshot_control;
    logic     swap_enable;
    logic     swap_trigger_select;
    logic     half_word_select;
    logic     gate_resync_enable;
    logic     inactive_bank_redirect;
    gcc_dir_e count_direction_field;
  } gcc_cfg_s;

  localparam gcc_cfg_s CFG_RESET = gcc_cfg_s'(8'h00);

endpackage : gcc_pkg

// *** gcc_tb.sv ***
// Self-checking bench of gcc_top: register traffic over AXI4-Lite plus pin stimulus.
// Assumes BREADY and RREADY may stay high and one write or read is under way at a time.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcc_pkg::*;
  logic              mclk, rst_b, awvalid, wvalid, arvalid;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rdv;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic [NCNT-1:0]   gate, updown, src, hw_off, armed, bank, ack;
  int                n_mismatch, n_compared;
  int                n_ack = 0;

  gcc_top dut_u (
    .MCLK_I(mclk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(1'b1), .GATE_I(gate),
    .UPDOWN_I(updown), .COUNT_SOURCE_I(src), .HW_DISARM_I(hw_off), .ARMED_O(armed),
    .ACTIVE_BANK_O(bank), .HALF_ACK_O(ack)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (ack[0] === 1'b1) n_ack <= n_ack + 1;

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic give_up;
    n_mismatch++;
    $display("wrong value at %0t: bus wait ran out", $time);
    print_verdict();
  endtask : give_up

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  // Samples armed or bank flags away from the clock edge
  task automatic cmp_pins(input bit sel, input logic [3:0] exp, input string what);
    @(negedge mclk);
    cmp_word({28'h0, sel ? bank : armed}, {28'h0, exp}, what);
    @(posedge mclk);
  endtask : cmp_pins

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic aw, w, b;
    int k;
    awaddr  <= {idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge mclk);
      aw = awready;
      w = wready;
      b = bvalid;
      rsp = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    if (k == 40) give_up();
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    logic a, r;
    int k;
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge mclk);
      a = arready;
      r = rvalid;
      rdv = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (a) arvalid <= 1'b0;
      if (r) break;
    end
    if (k == 40) give_up();
  endtask : rd

  task automatic rd_cmp(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] exp,
                        input string what);
    rd(idx);
    cmp_word(rdv & m, exp, what);
  endtask : rd_cmp

  task automatic tick(input int i);
    src[i] <= 1'b1;
    @(posedge mclk);
    src[i] <= 1'b0;
    @(posedge mclk);
  endtask : tick

  task automatic t_reset;
    rd_cmp(IDX_STATUS, 32'hffff, 32'h0, "status");
    rd_cmp(IDX_UPPER_STATUS, 32'hffff, 32'h0, "upper status");
    rd(IDX_CMD[0]);
    cmp_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "cmd read");
    rd(10'h3ff);
    cmp_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped");
    wr(IDX_UPPER_STATUS, 32'h1);
    cmp_word({30'h0, rsp}, {30'h0, RESP_SLVERR}, "status write");
    $display("test reset done");
  endtask : t_reset

  task automatic t_arm;
    for (int p = 0; p < 4; p += 2) begin
      wr(IDX_CMD[p], 32'h1);
      cmp_pins(1'b0, 4'h1 << p, "run");
      wr(IDX_CMD[p], 32'h2000);
      cmp_pins(1'b0, 4'h3 << p, "partner run");
      wr(IDX_CMD[p], 32'h10);
      cmp_pins(1'b0, 4'h2 << p, "stop");
      hw_off[p+1] <= 1'b1;
      @(posedge mclk);
      hw_off[p+1] <= 1'b0;
      cmp_pins(1'b0, 4'h0, "hw stop");
      wr(IDX_CMD[p+1], 32'h1);
      cmp_pins(1'b0, 4'h2 << p, "rerun");
      wr(IDX_CMD[p], 32'h8000);
      cmp_pins(1'b0, 4'h0, "partner stop");
    end
    $display("test arm done");
  endtask : t_arm

  task automatic t_gate;
    wr(IDX_CTRL, 32'h8);
    rd_cmp(IDX_UPPER_STATUS, 32'hf, 32'h8, "gate inverted");
    gate <= 4'h4;
    rd_cmp(IDX_UPPER_STATUS, 32'hf, 32'hc, "gate direct");
    wr(IDX_CMD[2], 32'h100);
    gate <= 4'h0;
    rd_cmp(IDX_UPPER_STATUS, 32'hf, 32'hc, "gate delayed");
    rd_cmp(IDX_UPPER_STATUS, 32'hf, 32'h8, "gate settled");
    $display("test gate done");
  endtask : t_gate

  task automatic t_count;
    logic [31:0] v;
    int n0;
    n0 = n_ack;
    wr(IDX_LOAD_A_BASE, 32'h5);
    wr(IDX_STEP[0], 32'h3);
    wr(IDX_CMD[0], 32'h5);
    repeat (6) tick(0);
    rd_cmp(IDX_LOAD_A_BASE, '1, 32'h8, "stepped load");
    tick(0);
    rd_cmp(IDX_SAVE_BASE, '1, 32'h4, "tracing save");
    wr(IDX_CMD[0], 32'h4000);
    repeat (2) tick(0);
    rd_cmp(IDX_SAVE_BASE, '1, 32'h4, "latched save");
    rd_cmp(IDX_STATUS, 32'h30, 32'h30, "save done");
    updown <= 4'h1;
    v = 32'h2;
    for (int d = 1; d < 4; d++) begin
      wr(IDX_CMD[0], 32'(d) << 5);
      tick(0);
      v = (d == 3) ? v - 32'h1 : v + 32'h1;
      rd_cmp(IDX_SAVE_BASE, '1, v, "direction");
    end
    wr(IDX_CMD[0], 32'h202);
    wstrb <= 4'h3;
    wr(IDX_LOAD_B_BASE, 32'h0);
    wstrb <= 4'hc;
    wr(IDX_LOAD_B_BASE, 32'h0);
    wstrb <= 4'hf;
    rd_cmp(IDX_STATUS, 32'h10, 32'h10, "own save");
    repeat (2) @(posedge mclk);
    cmp_word(32'(n_ack - n0), 32'h7, "acks");
    $display("test count done");
  endtask : t_count

  task automatic t_bank;
    wr(IDX_CMD[2], 32'h1000);
    wr(IDX_LOAD_B_BASE + 10'h2, 32'h7);
    wr(IDX_CMD[2], 32'h0);
    wr(IDX_LOAD_B_BASE + 10'h2, 32'h9);
    wr(IDX_CTRL, 32'h48);
    wr(IDX_CMD[2], 32'h1c01);
    cmp_pins(1'b1, 4'h4, "soft swap");
    rd_cmp(IDX_UPPER_STATUS, 32'h3, 32'h1, "bank flag");
    rd_cmp(IDX_LOAD_B_BASE + 10'h2, '1, 32'h7, "bank Y B");
    wr(IDX_CMD[2], 32'h1004);
    rd_cmp(IDX_SAVE_BASE + 10'h2, '1, 32'h7, "preset B");
    wr(IDX_CMD[2], 32'h1880);
    wr(IDX_LOAD_A_BASE + 10'h2, 32'h21);
    rd_cmp(IDX_LOAD_A_BASE + 10'h2, '1, 32'h0, "redirect");
    wr(IDX_CMD[2], 32'h1c00);
    rd_cmp(IDX_LOAD_A_BASE + 10'h2, '1, 32'h21, "bank X A");
    wr(IDX_CMD[2], 32'h1400);
    cmp_pins(1'b1, 4'h0, "no gate edge");
    gate <= 4'h4;
    repeat (3) @(posedge mclk);
    cmp_pins(1'b1, 4'h4, "gate swap");
    $display("test bank done");
  endtask : t_bank

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    wstrb = 4'hf;
    {rst_b, awvalid, wvalid, arvalid} = 4'h0;
    {awaddr, araddr, wdata} = '0;
    {gate, updown, src, hw_off} = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_arm();
    t_gate();
    t_count();
    t_bank();
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// *** gcc_top.sv ***
// Command, arming, direction, bank switching and save control of four counters.
// Assumes AXI4-Lite master, inputs synchronous to MCLK_I, count source as enable pulses.
//
// Overview of operation
// RL1: Upper pair status returns each counter's gate level after polarity inversion.
// RL2: A status bit per counter shows active load bank, 0 X, 1 Y.
// RL3: Each reload adds the 8-bit step value to Load A.
// RL4: Joint reset leaves step value unchanged; software writes zero for none; the code resets the step value to STEP_RESET with RST_B_I.
// RL5: Partner disarm bit disarms the other counter of the pair.
// RL6: Partner arm bit arms the other counter until disarmed.
// RL7: Partner snapshot bit applies snapshot control to both counters at once.
// RL8: Save register tracks counter when open, latches after next edge when set.
// RL9: Swap enable allows switching when armed, picks written bank when disarmed.
// RL10: Swap trigger select picks gate (0) or software (1) switch trigger.
// RL11: Swap request asks for a switch and clears itself when done.
// RL12: Half select picks low or high load/save half for acknowledge; the code acknowledges every save read whatever the half.
// RL13: Resync bit passes gate through a two-stage synchroniser.
// RL14: Redirect bit sends Load A writes to the inactive bank.
// RL15: Direction field: down, up, up/down pin, or internal gate.
// RL16: Stop strobe disarms that counter.
// RL17: Preset strobe copies selected load register A or B into counter.
// RL18: Run strobe arms counter until hardware or stop strobe disarms it.
// RL19: Save done flag sets once the save register has latched.
// RL20: Unused status bits read zero; software writes zero to unused bits.
`timescale 1ns/1ps
`default_nettype none

module gcc_top
  import gcc_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic              MCLK_I,
  input  wire logic              RST_B_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic [NCNT-1:0]   GATE_I,
  input  wire logic [NCNT-1:0]   UPDOWN_I,
  input  wire logic [NCNT-1:0]   COUNT_SOURCE_I,
  input  wire logic [NCNT-1:0]   HW_DISARM_I,
  output logic [NCNT-1:0]        ARMED_O,
  output logic [NCNT-1:0]        ACTIVE_BANK_O,
  output logic [NCNT-1:0]        HALF_ACK_O
);

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strobe_mask

  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old_v,
                                             input logic [31:0]      new_v,
                                             input logic [3:0]       strb);
    logic [31:0] m;
    m     = strobe_mask(strb);
    merge = CNT_W'((32'(old_v) & ~m) | (new_v & m));
  endfunction : merge

  // Bus slave state
  logic                 aw_held;
  logic                 w_held;
  logic [IDX_W-1:0]     w_idx;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic [31:0]          w_mdata;
  logic                 wr_fire;
  logic                 wr_ok;
  logic                 ar_fire;
  logic [IDX_W-1:0]     r_idx;
  logic [31:0]          rd_data;
  logic                 rd_ok;

  // Per-counter state
  gcc_cfg_s             cfg       [NCNT];
  logic [STEP_W-1:0]    reload_step_value [NCNT];
  logic [CNT_W-1:0]     cnt       [NCNT];
  logic [CNT_W-1:0]     save      [NCNT];
  logic [CNT_W-1:0]     load_a    [NCNT][2];
  logic [CNT_W-1:0]     load_b    [NCNT][2];
  logic [NCNT-1:0]      armed;
  logic [NCNT-1:0]      active_bank_flag;
  logic [NCNT-1:0]      swap_pend;
  logic [NCNT-1:0]      snap_latched;
  logic [NCNT-1:0]      snapshot_done_flag;
  logic [NCNT-1:0]      polarity;
  logic [NCNT-1:0]      preset_from_b;
  logic [NCNT-1:0]      gate_s1;
  logic [NCNT-1:0]      gate_s2;
  logic [NCNT-1:0]      gate_prev;
  logic [NCNT-1:0]      half_ack;

  // Per-counter decode
  gcc_cmd_s             cw        [NCNT];
  logic [NCNT-1:0]      gate_level_flag;
  logic [NCNT-1:0]      gate_rise;
  logic [NCNT-1:0]      count_up;
  logic [NCNT-1:0]      reload;
  logic [NCNT-1:0]      swap_now;
  logic [NCNT-1:0]      wb_a;
  logic [NCNT-1:0]      wb_b;
  logic [NCNT-1:0]      we_load_a;
  logic [NCNT-1:0]      we_load_b;
  logic [NCNT-1:0]      we_step;
  logic [NCNT-1:0]      half_hit;

  assign S_AXI_AWREADY_O = ~aw_held & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_held & ~S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
  assign wr_fire         = aw_held & w_held;
  assign ar_fire         = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  assign r_idx           = S_AXI_ARADDR_I[ADDR_W-1:2];
  // Held write data with unstrobed byte lanes forced to zero
  assign w_mdata         = w_data & strobe_mask(w_strb);
  assign ARMED_O         = armed;
  assign ACTIVE_BANK_O   = active_bank_flag;
  assign HALF_ACK_O      = half_ack;

  // Write address and data are taken in either order, then applied together
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_held <= 1'b0;
      w_idx   <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      w_idx   <= S_AXI_AWADDR_I[ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_data;
      S_AXI_RRESP_O  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // Command decode, gate path, direction and write targets
  always_comb begin
    wr_ok = wr_fire && (w_idx == IDX_CTRL);
    for (int i = 0; i < NCNT; i++) begin
      cw[i]        = '0;
      we_step[i]   = wr_fire && (w_idx == IDX_STEP[i]);
      we_load_a[i] = wr_fire && (w_idx == IDX_LOAD_A_BASE + IDX_W'(i));
      we_load_b[i] = wr_fire && (w_idx == IDX_LOAD_B_BASE + IDX_W'(i));
      if (wr_fire && (w_idx == IDX_CMD[i])) begin
        cw[i] = gcc_cmd_s'(w_mdata[15:0]);
        wr_ok = 1'b1;
      end
      if (we_step[i] || we_load_a[i] || we_load_b[i]) begin
        wr_ok = 1'b1;
      end
      gate_level_flag[i] = (cfg[i].gate_resync_enable ? gate_s2[i] : GATE_I[i])
                           ^ polarity[i]; // [RL13] [RL1]
      gate_rise[i] = gate_level_flag[i] & ~gate_prev[i];
      unique case (cfg[i].count_direction_field) // [RL15]
        DIR_DOWN: count_up[i] = 1'b0;
        DIR_UP:   count_up[i] = 1'b1;
        DIR_PIN:  count_up[i] = UPDOWN_I[i];
        DIR_GATE: count_up[i] = gate_level_flag[i];
      endcase
      reload[i] = armed[i] && COUNT_SOURCE_I[i] &&
                  (count_up[i] ? (&cnt[i]) : (cnt[i] == '0));
      swap_now[i] = armed[i] && cfg[i].swap_enable && swap_pend[i] &&
                    (cfg[i].swap_trigger_select || gate_rise[i]); // [RL9] [RL10]
      wb_b[i] = armed[i] ? active_bank_flag[i] : cfg[i].swap_enable; // [RL9]
      wb_a[i] = cfg[i].inactive_bank_redirect ? ~active_bank_flag[i] : wb_b[i]; // [RL14]
      half_hit[i] = cfg[i].half_word_select ? |w_strb[3:2] : |w_strb[1:0]; // [RL12]
    end
  end

  // Register read multiplexer; unused bits read zero
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b0;
    if (r_idx == IDX_UPPER_STATUS) begin
      rd_data[UST_GATE_LSB +: 2] = gate_level_flag[3:2]; // [RL1] [RL20]
      rd_data[UST_BANK_LSB +: 2] = active_bank_flag[3:2]; // [RL2]
      rd_ok = 1'b1;
    end
    if (r_idx == IDX_STATUS) begin
      rd_data[ST_ARMED_LSB +: NCNT] = armed;
      rd_data[ST_DONE_LSB +: NCNT]  = snapshot_done_flag; // [RL19]
      rd_data[ST_GATE_LSB +: NCNT]  = gate_level_flag;
      rd_data[ST_BANK_LSB +: NCNT]  = active_bank_flag; // [RL2]
      rd_ok = 1'b1;
    end
    if (r_idx == IDX_CTRL) begin
      rd_data[CTRL_POL_LSB +: NCNT]    = polarity;
      rd_data[CTRL_PRESET_LSB +: NCNT] = preset_from_b;
      rd_ok = 1'b1;
    end
    for (int i = 0; i < NCNT; i++) begin
      if (r_idx == IDX_LOAD_A_BASE + IDX_W'(i)) begin
        rd_data = 32'(load_a[i][active_bank_flag[i]]);
        rd_ok   = 1'b1;
      end
      if (r_idx == IDX_LOAD_B_BASE + IDX_W'(i)) begin
        rd_data = 32'(load_b[i][active_bank_flag[i]]);
        rd_ok   = 1'b1;
      end
      if (r_idx == IDX_SAVE_BASE + IDX_W'(i)) begin
        rd_data = 32'(save[i]);
        rd_ok   = 1'b1;
      end
    end
  end

  // Stored command levels and own control register
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < NCNT; i++) begin
        cfg[i] <= CFG_RESET;
      end
      polarity      <= '0;
      preset_from_b <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (wr_fire && (w_idx == IDX_CMD[i])) begin
          cfg[i].snapshot_control       <= cw[i].snapshot_control; // [RL8]
          cfg[i].swap_enable            <= cw[i].swap_enable;
          cfg[i].swap_trigger_select    <= cw[i].swap_trigger_select;
          cfg[i].half_word_select       <= cw[i].half_word_select;
          cfg[i].gate_resync_enable     <= cw[i].gate_resync_enable;
          cfg[i].inactive_bank_redirect <= cw[i].inactive_bank_redirect;
          cfg[i].count_direction_field  <= cw[i].count_direction_field;
        end
        if (cw[i].partner_snapshot_control || cw[i ^ 1].partner_snapshot_control) begin
          cfg[i].snapshot_control <= 1'b1; // [RL7]
        end
      end
      if (wr_fire && (w_idx == IDX_CTRL)) begin
        polarity      <= w_mdata[CTRL_POL_LSB +: NCNT];
        preset_from_b <= w_mdata[CTRL_PRESET_LSB +: NCNT];
      end
    end
  end

  // Step values reset to STEP_RESET with RST_B_I; only a bus write changes them
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < NCNT; i++) begin
        reload_step_value[i] <= STEP_RESET;
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (we_step[i] && w_strb[0]) begin
          reload_step_value[i] <= w_data[STEP_W-1:0]; // [RL4]
        end
      end
    end
  end

  // Arming; a set in the same cycle as a clear wins
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      armed <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (cw[i].run_strobe || cw[i ^ 1].partner_arm) begin
          armed[i] <= 1'b1; // [RL18] [RL6]
        end else if (cw[i].stop_strobe || cw[i ^ 1].partner_disarm || HW_DISARM_I[i]) begin
          armed[i] <= 1'b0; // [RL16] [RL5]
        end
      end
    end
  end

  // Gate synchroniser and edge history
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gate_s1   <= '0;
      gate_s2   <= '0;
      gate_prev <= '0;
    end else begin
      gate_s1   <= GATE_I;
      gate_s2   <= gate_s1; // [RL13]
      gate_prev <= gate_level_flag;
    end
  end

  // Bank switching; a new request in the switch cycle stays pending
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      active_bank_flag <= {NCNT{BANK_X}};
      swap_pend        <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (swap_now[i]) begin
          active_bank_flag[i] <= ~active_bank_flag[i]; // [RL2] [RL10]
        end
        if (cw[i].swap_request) begin
          swap_pend[i] <= 1'b1; // [RL11]
        end else if (swap_now[i]) begin
          swap_pend[i] <= 1'b0; // [RL11]
        end
      end
    end
  end

  // Load registers; a bus write wins over the reload step
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < NCNT; i++) begin
        load_a[i] <= '{default: '0};
        load_b[i] <= '{default: '0};
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (reload[i]) begin
          load_a[i][active_bank_flag[i]] <= load_a[i][active_bank_flag[i]]
                                          + CNT_W'(reload_step_value[i]); // [RL3]
        end
        if (we_load_a[i]) begin
          load_a[i][wb_a[i]] <= merge(load_a[i][wb_a[i]], w_data, w_strb); // [RL14]
        end
        if (we_load_b[i]) begin
          load_b[i][wb_b[i]] <= merge(load_b[i][wb_b[i]], w_data, w_strb); // [RL9]
        end
      end
    end
  end

  // Counter: preset, reload at terminal count, or one step
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < NCNT; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (cw[i].preset_strobe) begin
          cnt[i] <= preset_from_b[i] ? load_b[i][active_bank_flag[i]]
                                     : load_a[i][active_bank_flag[i]]; // [RL17]
        end else if (reload[i]) begin
          cnt[i] <= load_a[i][active_bank_flag[i]];
        end else if (armed[i] && COUNT_SOURCE_I[i]) begin
          cnt[i] <= count_up[i] ? cnt[i] + CNT_W'(1) : cnt[i] - CNT_W'(1); // [RL15]
        end
      end
    end
  end

  // Save register: open tracks, set latches one edge later, then done
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < NCNT; i++) begin
        save[i] <= '0;
      end
      snap_latched       <= '0;
      snapshot_done_flag <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        if (!cfg[i].snapshot_control) begin
          save[i]               <= cnt[i]; // [RL8]
          snap_latched[i]       <= 1'b0;
          snapshot_done_flag[i] <= 1'b0;
        end else if (!snap_latched[i]) begin
          save[i]         <= cnt[i]; // [RL8]
          snap_latched[i] <= 1'b1;
        end else begin
          snapshot_done_flag[i] <= 1'b1; // [RL19]
        end
      end
    end
  end

  // Acknowledge trigger on the chosen half of a load write, or on any save read
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      half_ack <= '0;
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        half_ack[i] <= ((we_load_a[i] || we_load_b[i]) && half_hit[i]) ||
                       (ar_fire && (r_idx == IDX_SAVE_BASE + IDX_W'(i))); // [RL12]
      end
    end
  end

endmodule : gcc_top

`default_nettype wire
